// >>> rtl/mslri_pkg.sv
// Constants for the module sideband low-power, reset and interrupt block.
// Assumes a single 200 MHz clock and comparator outputs arriving as
// plain levels from the line threshold circuits.
package mslri_pkg;

  // Clock rate in kHz, so that cycle counts derive from times
  localparam int unsigned CLK_KHZ         = 200000;

  // Longest high-power to low-power transition time, in microseconds
  localparam int unsigned T_HPLP_US       = 200;
  localparam int unsigned T_HPLP_CYC      = (T_HPLP_US * CLK_KHZ) / 1000;

  // Synchroniser depth and values taken at reset
  localparam int unsigned SYNC_STAGES     = 2;
  localparam logic        RST_LP_N        = 1'b0; // Low power asserted
  localparam logic        RST_MRST_N      = 1'b0; // Module reset asserted
  localparam logic        RST_PIN_HIGH    = 1'b1; // Idle open-drain line
  localparam logic        RST_OE_N        = 1'b1; // Not driving
  localparam logic        RST_TX_EN       = 1'b0;
  localparam logic        RST_IRQ         = 1'b0;
  localparam logic        RST_LP_MODE     = 1'b1; // Low power held
  localparam logic        RST_IN_RESET    = 1'b1; // Reset reported
  localparam logic        RST_PIN_DRIVE   = 1'b0; // Level when enabled

  // Power class encoding: 0 is class I up to 3 for class IV
  localparam logic [1:0]  PCLASS_I        = 2'h0;
  localparam logic [1:0]  PCLASS_II       = 2'h1;

  // Operating states, Gray coded along reset, low power, operating
  typedef enum logic [1:0] {
    MSLRI_ST_RESET  = 2'h0,
    MSLRI_ST_LOWPWR = 2'h1,
    MSLRI_ST_OPER   = 2'h3
  } mslri_state_e;

endpackage

// >>> rtl/mslri_sync.sv
// Two-stage level synchroniser for pin and comparator inputs.
// Assumes the input may change at any time relative to clock_in.
module mslri_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clock_in,
  input  wire logic reset_in,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      meta_r   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// >>> rtl/mslri_top.sv
// Module-side sideband controller: low-power and reset decoding, transmit
// enable, interrupt drive and the open-drain management pins.
// Assumes comparator outputs and pins are asynchronous, and that the
// management core and interrupt sources run on clock_in.

// Notes on behaviour
// - Host low-power request is active low, seen active low after decode.
// - Module shows presence by pull-down; host decodes it active low.
// - Three line zones: low power present, high power present, absent.
// - Lost contact pulls low-power asserted; go class I, transmitters off.
// - Reach low power within 200 us of low-power or reset assertion.
// - Class I/II may omit low-power decode, losing transmitter disable.
// - Class III and IV must decode the low-power request.
// - Host reset active low, seen as active-low reset after decode.
// - Module interrupt active high; host decodes it active low.
// - Lowest reset-line zone: module in reset, no interrupt.
// - Middle zone: out of reset, normal, interrupt deasserted.
// - Interrupt only raised while out of reset.
// - Management over open-drain two-wire link pulled up on host.
// - At reset release enter low power or operating per low-power input.
// - Transmitters on only with low-power deasserted and force bit 0.
module mslri_top #(
  parameter int unsigned HPLP_CYCLES = mslri_pkg::T_HPLP_CYC
) (
  input  wire logic       clock_in,
  input  wire logic       reset_in,
  input  wire logic       module_side_low_power_n_in,
  input  wire logic       module_side_reset_n_in,
  input  wire logic       lp_decode_fitted_in,
  input  wire logic [1:0] power_class_in,
  input  wire logic       force_low_power_bit_in,
  input  wire logic       irq_request_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       sda_pull_low_in,
  input  wire logic       scl_pull_low_in,
  output logic            tx_enable_out,
  output logic            low_power_mode_out,
  output logic [1:0]      power_class_out,
  output logic            module_in_reset_out,
  output logic            irq_drive_out,
  output logic            scl_sync_out,
  output logic            sda_sync_out,
  output logic            scl_out,
  output logic            scl_oe_n_out,
  output logic            sda_out,
  output logic            sda_oe_n_out
);

  logic                    lp_n_sync;
  logic                    rst_n_sync;
  logic                    scl_sync;
  logic                    sda_sync;
  logic                    decode_on;
  logic                    lp_req;
  logic                    in_reset;
  logic                    oper_nxt;
  mslri_pkg::mslri_state_e state_r;
  mslri_pkg::mslri_state_e state_nxt;

  // Comparator and pin synchronisers
  mslri_sync #(.RESET_VAL(mslri_pkg::RST_LP_N)) u_sync_lp (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .async_in (module_side_low_power_n_in),
    .sync_out (lp_n_sync)
  );
  mslri_sync #(.RESET_VAL(mslri_pkg::RST_MRST_N)) u_sync_rst (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .async_in (module_side_reset_n_in),
    .sync_out (rst_n_sync)
  );
  mslri_sync #(.RESET_VAL(mslri_pkg::RST_PIN_HIGH)) u_sync_scl (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .async_in (scl_in),
    .sync_out (scl_sync)
  );
  mslri_sync #(.RESET_VAL(mslri_pkg::RST_PIN_HIGH)) u_sync_sda (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .async_in (sda_in),
    .sync_out (sda_sync)
  );

  // Decode may be left out only by class I or II parts
  assign decode_on = lp_decode_fitted_in
                   | (power_class_in > mslri_pkg::PCLASS_II);

  // Active-low request, plus the management force bit
  assign lp_req   = (decode_on & ~lp_n_sync)
                  | force_low_power_bit_in;
  assign in_reset = ~rst_n_sync;

  // With decode on, zone 2 of the low-power line is the only way to full power
  assign oper_nxt = (state_nxt == mslri_pkg::MSLRI_ST_OPER);

  // Next state: reset dominates, then the low-power table
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      mslri_pkg::MSLRI_ST_RESET,
      mslri_pkg::MSLRI_ST_LOWPWR,
      mslri_pkg::MSLRI_ST_OPER:
      begin
        if (in_reset)
          state_nxt = mslri_pkg::MSLRI_ST_RESET;
        else if (lp_req)
          state_nxt = mslri_pkg::MSLRI_ST_LOWPWR;
        else
          state_nxt = mslri_pkg::MSLRI_ST_OPER;
      end
      default:
        state_nxt = mslri_pkg::MSLRI_ST_RESET;
    endcase
  end

  // State register
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      state_r <= mslri_pkg::MSLRI_ST_RESET;
    else
      state_r <= state_nxt;
  end

  // Power outputs follow the state in the same edge
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      tx_enable_out       <= mslri_pkg::RST_TX_EN;
      low_power_mode_out  <= mslri_pkg::RST_LP_MODE;
      power_class_out     <= mslri_pkg::PCLASS_I;
      module_in_reset_out <= mslri_pkg::RST_IN_RESET;
    end
    else
    begin
      // Removal pulls the request low: class I, transmitters off
      tx_enable_out       <= oper_nxt;
      low_power_mode_out  <= ~oper_nxt;
      power_class_out     <= oper_nxt ? power_class_in
                                      : mslri_pkg::PCLASS_I;
      module_in_reset_out <= in_reset;
    end
  end

  // Interrupt drive, held off and cleared during reset
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      irq_drive_out <= mslri_pkg::RST_IRQ;
    else
      irq_drive_out <= irq_request_in & ~in_reset;
  end

  // Open-drain management pins: drive low or release
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      scl_out      <= mslri_pkg::RST_PIN_DRIVE;
      sda_out      <= mslri_pkg::RST_PIN_DRIVE;
      scl_oe_n_out <= mslri_pkg::RST_OE_N;
      sda_oe_n_out <= mslri_pkg::RST_OE_N;
      scl_sync_out <= mslri_pkg::RST_PIN_HIGH;
      sda_sync_out <= mslri_pkg::RST_PIN_HIGH;
    end
    else
    begin
      scl_out      <= 1'b0;
      sda_out      <= 1'b0;
      scl_oe_n_out <= ~scl_pull_low_in;
      sda_oe_n_out <= ~sda_pull_low_in;
      scl_sync_out <= scl_sync;
      sda_sync_out <= sda_sync;
    end
  end

  // Helper: cycles spent operating while low power or reset is requested
  logic [31:0] hplp_cnt_r;
  always_ff @(posedge clock_in)
  begin
    if (reset_in || !(lp_req || in_reset) || !tx_enable_out)
      hplp_cnt_r <= 32'h0;
    else
      hplp_cnt_r <= hplp_cnt_r + 32'h1;
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  a_hplp_deadline: assert property (hplp_cnt_r < HPLP_CYCLES)
    else $error("low power not reached in time");
  a_lp_tx_off: assert property (
    (decode_on && !lp_n_sync) |=> !tx_enable_out && low_power_mode_out)
    else $error("transmitter on while low power requested");
  a_force_bit: assert property (
    force_low_power_bit_in |=> !tx_enable_out)
    else $error("force bit did not hold transmitter off");
  a_tx_on_cond: assert property (
    (rst_n_sync && lp_n_sync && !force_low_power_bit_in) |=> tx_enable_out)
    else $error("transmitter not enabled when allowed");
  a_reset_off: assert property (
    !rst_n_sync |=> !tx_enable_out && !irq_drive_out && module_in_reset_out)
    else $error("reset did not quiet the module");
  a_irq_follow: assert property (
    irq_drive_out |-> $past(irq_request_in) && !module_in_reset_out)
    else $error("interrupt without cause or during reset");
  a_removal_class: assert property (
    (decode_on && $fell(lp_n_sync)) |=> power_class_out == mslri_pkg::PCLASS_I)
    else $error("removal did not drop to class one");
  a_release_mode: assert property (
    ($rose(rst_n_sync) && !lp_req) |=>
      tx_enable_out && !low_power_mode_out && !module_in_reset_out)
    else $error("no operation after reset release");
  a_omit_decode: assert property (
    (!decode_on && rst_n_sync && !force_low_power_bit_in) |=> tx_enable_out)
    else $error("omitted decode still disabled transmitter");
  a_od_level: assert property (
    !sda_oe_n_out |-> !sda_out && $past(sda_pull_low_in))
    else $error("open drain drove a high level");

  c_oper: cover property ($rose(tx_enable_out));
  c_lp_entry: cover property ($fell(tx_enable_out) && rst_n_sync);
  c_irq: cover property ($rose(irq_drive_out));
  c_reset: cover property ($rose(module_in_reset_out));

endmodule

// >>> test/mslri_host_model.sv
// Host-side model of the two sideband lines and the management wires.
// Assumes the bench sets the host controls and the design drives its side.
module mslri_host_model (
  input  wire logic installed_in,
  input  wire logic lp_drive_n_in,
  input  wire logic rst_drive_n_in,
  input  wire logic irq_drive_in,
  input  wire logic scl_oe_n_in,
  input  wire logic sda_oe_n_in,
  input  wire logic host_scl_low_in,
  input  wire logic host_sda_low_in,
  output logic      lp_n_out,
  output logic      rst_n_out,
  output logic      present_n_out,
  output logic      host_irq_n_out,
  output logic      scl_out,
  output logic      sda_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Host drives high or open; the module pull-down wins on lost contact
  assign lp_n_out = installed_in & lp_drive_n_in;
  // Upper zone reads absent; a grounded contact reads present
  assign present_n_out = ~installed_in;
  // Lowest zone holds reset, also with no module fitted
  assign rst_n_out = installed_in & rst_drive_n_in;
  // Interrupt zone needs the module out of reset
  assign host_irq_n_out = ~(rst_n_out & irq_drive_in);
  // Open-drain wires with host pull-ups
  assign scl_out = ~(host_scl_low_in | ~scl_oe_n_in);
  assign sda_out = ~(host_sda_low_in | ~sda_oe_n_in);
endmodule

// >>> test/test_mslri_top.sv
// Self-checking bench for the module-side sideband controller.
// Assumes the host model closes the lines; outputs settle in 4 edges.
module test_mslri_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock_in = 1'b0;
  logic       reset_in = 1'b1;
  logic       inst     = 1'b1;
  logic       lp_dr    = 1'b1;
  logic       rst_dr   = 1'b1;
  logic       force_lp = 1'b0;
  logic       fit      = 1'b1;
  logic [1:0] cls      = 2'h2;
  logic       irq_rq   = 1'b0;
  logic       spl      = 1'b0;
  logic       dpl      = 1'b0;
  logic       hsl      = 1'b0;
  logic       hdl      = 1'b0;
  logic       lp_n, rst_n, pres_n, hirq_n, scl, sda, tx, lpm, inr, irqd;
  logic       ssync, dsync, scl_oe, sda_oe, scl_o, sda_o;
  logic [1:0] cls_o;
  int         miscompares = 0;
  int         total_checks = 0;
  int         n;
  // Corner vectors: inst,lp,rst,force,fit,class,irq,spl,dpl,hsl,hdl
  localparam logic [11:0] CORNER [8] = '{12'hEB0, 12'hAB0, 12'hFB0,
    12'h6B0, 12'hE8A, 12'hA05, 12'hA25, 12'hF3F};
  mslri_top #(.HPLP_CYCLES(64)) mslri_top_i (
    .clock_in(clock_in), .reset_in(reset_in),
    .module_side_low_power_n_in(lp_n), .module_side_reset_n_in(rst_n),
    .lp_decode_fitted_in(fit), .power_class_in(cls),
    .force_low_power_bit_in(force_lp), .irq_request_in(irq_rq),
    .scl_in(scl), .sda_in(sda), .sda_pull_low_in(dpl),
    .scl_pull_low_in(spl), .tx_enable_out(tx), .low_power_mode_out(lpm),
    .power_class_out(cls_o), .module_in_reset_out(inr),
    .irq_drive_out(irqd), .scl_sync_out(ssync), .sda_sync_out(dsync),
    .scl_out(scl_o), .scl_oe_n_out(scl_oe), .sda_out(sda_o),
    .sda_oe_n_out(sda_oe));
  mslri_host_model mslri_host_model_i (
    .installed_in(inst), .lp_drive_n_in(lp_dr), .rst_drive_n_in(rst_dr),
    .irq_drive_in(irqd), .scl_oe_n_in(scl_oe), .sda_oe_n_in(sda_oe),
    .host_scl_low_in(hsl), .host_sda_low_in(hdl), .lp_n_out(lp_n),
    .rst_n_out(rst_n), .present_n_out(pres_n), .host_irq_n_out(hirq_n),
    .scl_out(scl), .sda_out(sda));
  // Free-running 200 MHz clock
  always #2.5 clock_in = ~clock_in;
  // Transmit enable expected from line levels, force bit and class
  function automatic logic exp_tx(input logic r, input logic l);
    logic e;
    e = (fit | cls[1]) ? l : 1'b1;
    return r & e & ~force_lp;
  endfunction
  task automatic check_bit(input logic got, input logic exp, string what);
    total_checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: %s", $time, what);
      miscompares++;
    end
  endtask
  task automatic check_class(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: class", $time);
      miscompares++;
    end
  endtask
  task automatic check_all();
    logic r;
    logic t;
    r = inst & rst_dr;
    t = exp_tx(r, inst & lp_dr);
    check_bit(tx, t, "tx enable");
    check_bit(lpm, ~t, "low power");
    check_class(cls_o, t ? cls : 2'h0);
    check_bit(inr, ~r, "in reset");
    check_bit(irqd, r & irq_rq, "irq");
    check_bit(hirq_n, ~(r & irq_rq), "host irq");
    check_bit(scl_oe, ~spl, "scl oe");
    check_bit(sda_oe, ~dpl, "sda oe");
    check_bit(scl_o, 1'b0, "scl level");
    check_bit(sda_o, 1'b0, "sda level");
    check_bit(ssync, ~(spl | hsl), "scl sync");
    check_bit(dsync, ~(dpl | hdl), "sda sync");
    check_bit(pres_n, ~inst, "present");
  endtask
  // Values held while the local reset is asserted
  task automatic check_reset();
    check_bit(tx, mslri_pkg::RST_TX_EN, "reset tx");
    check_bit(lpm, mslri_pkg::RST_LP_MODE, "reset lp");
    check_class(cls_o, mslri_pkg::PCLASS_I);
    check_bit(inr, mslri_pkg::RST_IN_RESET, "reset inr");
    check_bit(irqd, mslri_pkg::RST_IRQ, "reset irq");
    check_bit(scl_oe, mslri_pkg::RST_OE_N, "reset scl oe");
    check_bit(sda_oe, mslri_pkg::RST_OE_N, "reset sda oe");
    check_bit(ssync, mslri_pkg::RST_PIN_HIGH, "reset scl sync");
    check_bit(dsync, mslri_pkg::RST_PIN_HIGH, "reset sda sync");
  endtask
  // Apply a vector at an edge and compare once the pipeline settles
  task automatic apply(input logic [11:0] v);
    @(posedge clock_in);
    {inst, lp_dr, rst_dr, force_lp, fit, cls, irq_rq} <= v[11:4];
    {spl, dpl, hsl, hdl} <= v[3:0];
    repeat (4) @(posedge clock_in);
    #1;
    check_all();
  endtask
  task automatic complete_run();
    $display("miscompares %0d total_checks %0d", miscompares, total_checks);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Reset values, reset release, corner vectors, then random traffic
  initial
  begin
    void'($urandom(32'hF9C3523E));
    repeat (20) @(posedge clock_in);
    #1;
    check_reset();
    @(posedge clock_in);
    reset_in <= 1'b0;
    for (n = 0; n < 10 && tx !== 1'b1; n++)
      @(posedge clock_in);
    if (n == 10)
    begin
      $display("wrong value at %0t: no start", $time);
      miscompares++;
    end
    else
    begin
      #1;
      check_all();
      foreach (CORNER[i])
        apply(CORNER[i]);
      repeat (60)
        apply(12'($urandom));
    end
    complete_run();
  end
endmodule
